//--- hdl/ctrl_consts.svh
`ifndef CTRL_CONSTS_SVH
`define CTRL_CONSTS_SVH
`define CTRL_NUM_CH          4
`define CTRL_TXCKSEL_RST     1'b1
`define CTRL_TXRATE_RST      1'b0
`define CTRL_RFEN_RST        1'b1
`define CTRL_RXPWR_RST       1'b0
`define CTRL_RXST_RST        1'b1
`define CTRL_TXST_RST        1'b1
`define CTRL_OE2_RST         1'b0
`define CTRL_OE1_RST         1'b0
`define CTRL_MULT_LOW        5'h0a
`define CTRL_MULT_HIGH       5'h14
`define CTRL_FIELD_TXCKSEL   0
`define CTRL_FIELD_TXRATE    1
`define CTRL_FIELD_RFEN      2
`define CTRL_FIELD_RXPWR     3
`define CTRL_FIELD_RXST      4
`define CTRL_FIELD_TXST      5
`define CTRL_FIELD_OE2       6
`define CTRL_FIELD_OE1       7
`define CTRL_NUM_FIELDS      8
`define CTRL_LATCH_RST       8'h35
`endif

//--- hdl/ctrl_pkg.sv
package ctrl_pkg;
   typedef logic [7:0] ctrl_latch_t;
   typedef enum logic [1:0] {
      CTRL_CLK_REF   = 2'h0,
      CTRL_CLK_TXIN  = 2'h1,
      CTRL_CLK_DDR   = 2'h3
   } ctrl_clksrc_t;
endpackage

//--- hdl/ctrl_latch_bank.sv
`timescale 1ns/10ps
`include "ctrl_consts.svh"
module ctrl_latch_bank
   import ctrl_pkg::*;
(
   input  wire  logic                 mclk,
   input  wire  logic                 rstSync_n,
   input  wire  logic [1:0]           wrChannel,
   input  wire  logic                 wrEnable,
   input  wire  ctrl_latch_t          wrData,
   output ctrl_latch_t                latch_q [`CTRL_NUM_CH]
);
   ////////////////////////////////////////////////////////////////////////////
   // One latch word per channel so channels are configured independently.
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         for (int i = 0; i < `CTRL_NUM_CH; i++) begin
            latch_q[i] <= `CTRL_LATCH_RST;
         end
      end else if (wrEnable) begin
         latch_q[wrChannel] <= wrData;
      end
   end
endmodule

//--- hdl/ctrl_channel_config.sv
`timescale 1ns/10ps
`include "ctrl_consts.svh"
module ctrl_channel_config
   import ctrl_pkg::*;
(
   input  wire  logic                 mclk,
   input  wire  logic                 rst_n,
   input  wire  logic                 wrEnable,
   input  wire  logic [1:0]           wrChannel,
   input  wire  logic [7:0]           wrData,
   input  wire  logic [3:0]           speedRangeSelect,
   output logic [3:0]                 txInputClockSelect,
   output logic [3:0]                 txPllRateSelect,
   output ctrl_clksrc_t               txClockSource [4],
   output logic [3:0]                 txPhaseBufferBypass,
   output logic [3:0]                 txDoubleEdgeCapture,
   output logic [4:0]                 txPllMultiplier [4],
   output logic [3:0]                 txClockOutDouble,
   output logic [3:0]                 framerEnable,
   output logic [3:0]                 frameOffsetHold,
   output logic [3:0]                 rxChannelPowerOn,
   output logic [3:0]                 rxSelftestOff,
   output logic [3:0]                 txSelftestOff,
   output logic [3:0]                 rxSelftestActive,
   output logic [3:0]                 txSelftestActive,
   output logic [3:0]                 primaryOutputEnable,
   output logic [3:0]                 secondaryOutputEnable,
   output logic [3:0]                 primaryDriverPowerDown,
   output logic [3:0]                 secondaryDriverPowerDown,
   output logic [3:0]                 txLogicPowerDown,
   output logic [3:0]                 rateComboInvalid
);
   ////////////////////////////////////////////////////////////////////////////
   logic        rstMeta_q;
   logic        rstSync_q;
   ctrl_latch_t latch_q [`CTRL_NUM_CH];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   ctrl_latch_bank uBank (
      .mclk      (mclk),
      .rstSync_n (rstSync_q),
      .wrChannel (wrChannel),
      .wrEnable  (wrEnable),
      .wrData    (wrData),
      .latch_q   (latch_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   function automatic ctrl_clksrc_t clkSource(input logic cksel, input logic rate);
      if (!cksel) begin
         clkSource = CTRL_CLK_TXIN;
      end else if (rate) begin
         clkSource = CTRL_CLK_DDR;
      end else begin
         clkSource = CTRL_CLK_REF;
      end
   endfunction

   // A driver counts as enabled only once the synchronised reset is released.
   function automatic logic driverLive(input logic live, input logic en);
      driverLive = live & en;
   endfunction

   // Multiplier for the transmit PLL chosen by the rate select bit.
   function automatic logic [4:0] pllMultiplier(input logic rate);
      if (rate) begin
         pllMultiplier = `CTRL_MULT_HIGH;
      end else begin
         pllMultiplier = `CTRL_MULT_LOW;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Driver enables drop on rst_n itself rather than on the synchronised copy,
   // so no driver keeps sending while the device sits in reset.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         primaryOutputEnable   <= 4'h0;
         secondaryOutputEnable <= 4'h0;
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            primaryOutputEnable[c]   <= driverLive(rstSync_q,
                                                   latch_q[c][`CTRL_FIELD_OE1]);
            secondaryOutputEnable[c] <= driverLive(rstSync_q,
                                                   latch_q[c][`CTRL_FIELD_OE2]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Each disabled driver is powered down on its own.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         primaryDriverPowerDown   <= 4'hf;
         secondaryDriverPowerDown <= 4'hf;
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            primaryDriverPowerDown[c]   <= ~driverLive(rstSync_q,
                                                       latch_q[c][`CTRL_FIELD_OE1]);
            secondaryDriverPowerDown[c] <= ~driverLive(rstSync_q,
                                                       latch_q[c][`CTRL_FIELD_OE2]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The channel transmit logic sleeps only when neither driver is live.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txLogicPowerDown <= 4'hf;
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            txLogicPowerDown[c] <= ~(driverLive(rstSync_q, latch_q[c][`CTRL_FIELD_OE1])
                                   | driverLive(rstSync_q, latch_q[c][`CTRL_FIELD_OE2]));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input register clock source and phase buffer bypass.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txInputClockSelect  <= {4{`CTRL_TXCKSEL_RST}};
         txPhaseBufferBypass <= 4'hf;
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            txClockSource[c] <= CTRL_CLK_REF;
         end
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            txInputClockSelect[c]  <= latch_q[c][`CTRL_FIELD_TXCKSEL];
            txClockSource[c]       <= clkSource(latch_q[c][`CTRL_FIELD_TXCKSEL],
                                                latch_q[c][`CTRL_FIELD_TXRATE]);
            txPhaseBufferBypass[c] <= latch_q[c][`CTRL_FIELD_TXCKSEL];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit PLL multiplier and the rate of the transmit clock output.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txPllRateSelect  <= {4{`CTRL_TXRATE_RST}};
         txClockOutDouble <= 4'h0;
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            txPllMultiplier[c] <= `CTRL_MULT_LOW;
         end
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            txPllRateSelect[c]  <= latch_q[c][`CTRL_FIELD_TXRATE];
            txPllMultiplier[c]  <= pllMultiplier(latch_q[c][`CTRL_FIELD_TXRATE]);
            txClockOutDouble[c] <= latch_q[c][`CTRL_FIELD_TXRATE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Double-edge capture needs both the reference clock and the doubled rate.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txDoubleEdgeCapture <= 4'h0;
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            txDoubleEdgeCapture[c] <= latch_q[c][`CTRL_FIELD_TXCKSEL]
                                      & latch_q[c][`CTRL_FIELD_TXRATE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The combination is the host's to avoid; it is only flagged here, since
   // blocking it would hide a host fault instead of reporting it.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rateComboInvalid <= 4'h0;
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            rateComboInvalid[c] <= latch_q[c][`CTRL_FIELD_TXRATE]
                                   & ~speedRangeSelect[c];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive framer enable and the frame offset hold that goes with it.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         framerEnable    <= {4{`CTRL_RFEN_RST}};
         frameOffsetHold <= 4'h0;
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            framerEnable[c]    <= latch_q[c][`CTRL_FIELD_RFEN];
            frameOffsetHold[c] <= ~latch_q[c][`CTRL_FIELD_RFEN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive PLL and analog power.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rxChannelPowerOn <= {4{`CTRL_RXPWR_RST}};
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            rxChannelPowerOn[c] <= latch_q[c][`CTRL_FIELD_RXPWR];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self-test latches are active low; the active outputs are their inverse.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rxSelftestOff    <= {4{`CTRL_RXST_RST}};
         txSelftestOff    <= {4{`CTRL_TXST_RST}};
         rxSelftestActive <= 4'h0;
         txSelftestActive <= 4'h0;
      end else begin
         for (int c = 0; c < `CTRL_NUM_CH; c++) begin
            rxSelftestOff[c]    <= latch_q[c][`CTRL_FIELD_RXST];
            txSelftestOff[c]    <= latch_q[c][`CTRL_FIELD_TXST];
            rxSelftestActive[c] <= ~latch_q[c][`CTRL_FIELD_RXST];
            txSelftestActive[c] <= ~latch_q[c][`CTRL_FIELD_TXST];
         end
      end
   end
endmodule

//--- bench/ctrl_channel_config_asserts.sv
`timescale 1ns/10ps
`include "ctrl_consts.svh"
module ctrl_channel_config_asserts
   import ctrl_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       wrEnable,
   input wire logic [1:0] wrChannel,
   input wire logic [7:0] wrData,
   input wire logic [3:0] txInputClockSelect,
   input wire logic [3:0] txPllRateSelect,
   input wire logic [3:0] txDoubleEdgeCapture,
   input wire logic [4:0] txPllMultiplier [4],
   input wire logic [3:0] framerEnable,
   input wire logic [3:0] frameOffsetHold,
   input wire logic [3:0] rxChannelPowerOn,
   input wire logic [3:0] rxSelftestOff,
   input wire logic [3:0] txSelftestOff,
   input wire logic [3:0] rxSelftestActive,
   input wire logic [3:0] primaryOutputEnable,
   input wire logic [3:0] secondaryOutputEnable,
   input wire logic [3:0] primaryDriverPowerDown,
   input wire logic [3:0] txLogicPowerDown
);
   // Writes in the first two cycles after reset are dropped by the synchroniser.
   logic [1:0] up_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   function automatic logic [7:0] word(input logic [1:0] i);
      return {primaryOutputEnable[i], secondaryOutputEnable[i], txSelftestOff[i],
              rxSelftestOff[i], rxChannelPowerOn[i], framerEnable[i],
              txPllRateSelect[i], txInputClockSelect[i]};
   endfunction
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   write_lands_a: assert property (up_q[1] && wrEnable |->
      ##2 word($past(wrChannel, 2)) == $past(wrData, 2)) else $error("latch word lost");
   pll_mult_a: assert property (txPllMultiplier[wrChannel] ==
      (txPllRateSelect[wrChannel] ? 5'h14 : 5'h0a)) else $error("multiplier wrong");
   double_edge_a: assert property (txDoubleEdgeCapture ==
      (txInputClockSelect & txPllRateSelect)) else $error("double edge wrong");
   frame_hold_a: assert property (frameOffsetHold == ~framerEnable)
      else $error("frame hold wrong");
   rx_selftest_a: assert property (rxSelftestActive == ~rxSelftestOff)
      else $error("rx selftest wrong");
   driver_pd_a: assert property (primaryDriverPowerDown == ~primaryOutputEnable)
      else $error("driver power wrong");
   tx_logic_pd_a: assert property (txLogicPowerDown ==
      ~(primaryOutputEnable | secondaryOutputEnable)) else $error("tx logic power wrong");
   latch_hold_a: assert property (!$past(wrEnable, 2) |->
      $stable({rxChannelPowerOn, rxSelftestOff, txSelftestOff})) else $error("latch moved");
endmodule
bind ctrl_channel_config ctrl_channel_config_asserts chk (.*);

//--- bench/ctrl_host_model.sv
`timescale 1ns/10ps
module ctrl_host_model (
   output logic       wrEnable,
   output logic [1:0] wrChannel,
   output logic [7:0] wrData
);
   initial {wrEnable, wrChannel, wrData} = 11'h0;
   // An idle bus shows the inverse of the last word, so stale data never passes for a write.
   task automatic put(input logic en, input logic [1:0] ch, input logic [7:0] d);
      wrEnable  <= en;
      wrChannel <= en ? ch : ~wrChannel;
      wrData    <= en ? d : ~wrData;
   endtask
endmodule

//--- bench/channel_tx_rx_config_latches_tb.sv
`timescale 1ns/10ps
module channel_tx_rx_config_latches_tb import ctrl_pkg::*;;
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic [3:0] speedRangeSelect = 4'hf;
   logic       wrEnable;
   logic [1:0] wrChannel;
   logic [7:0] wrData;
   logic [7:0] exp [4] = '{8'h35, 8'h35, 8'h35, 8'h35};
   logic [7:0] corner [6] = '{8'hff, 8'h00, 8'hc0, 8'h3d, 8'h02, 8'h81};
   integer     seed = 32'h9c83, num_errors = 0, check_count = 0;
   always #2.5 mclk = ~mclk;
   ctrl_host_model host (.wrEnable(wrEnable), .wrChannel(wrChannel), .wrData(wrData));
   ctrl_channel_config dut (.mclk(mclk), .rst_n(rst_n), .wrEnable(wrEnable),
      .wrChannel(wrChannel), .wrData(wrData), .speedRangeSelect(speedRangeSelect),
      .txInputClockSelect(), .txPllRateSelect(), .txClockSource(), .txPhaseBufferBypass(),
      .txDoubleEdgeCapture(), .txPllMultiplier(), .txClockOutDouble(), .framerEnable(),
      .frameOffsetHold(), .rxChannelPowerOn(), .rxSelftestOff(), .txSelftestOff(),
      .rxSelftestActive(), .txSelftestActive(), .primaryOutputEnable(),
      .secondaryOutputEnable(), .primaryDriverPowerDown(), .secondaryDriverPowerDown(),
      .txLogicPowerDown(), .rateComboInvalid());
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      check_count++;
      if (got !== want) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic checkAll(input string name);
      for (int i = 0; i < 4; i++) begin
         logic [7:0] e;
         e = exp[i];
         chk({dut.primaryOutputEnable[i], dut.secondaryOutputEnable[i], dut.txSelftestOff[i],
            dut.rxSelftestOff[i], dut.rxChannelPowerOn[i], dut.framerEnable[i],
            dut.txPllRateSelect[i], dut.txInputClockSelect[i]}, e);
         chk(8'(dut.txClockSource[i]),
            8'(e[0] ? (e[1] ? CTRL_CLK_DDR : CTRL_CLK_REF) : CTRL_CLK_TXIN));
         chk(8'(dut.txPllMultiplier[i]), e[1] ? 8'h14 : 8'h0a);
         chk({dut.txPhaseBufferBypass[i], dut.txDoubleEdgeCapture[i], dut.txLogicPowerDown[i],
            dut.secondaryDriverPowerDown[i], dut.txSelftestActive[i], dut.txClockOutDouble[i],
            dut.rateComboInvalid[i]}, {1'b0, e[0], e[0] & e[1], ~(e[7] | e[6]), ~e[6], ~e[5],
            e[1], 1'b0});
      end
      $display("test %s done", name);
   endtask
   task automatic wr(input logic [1:0] ch, input logic [7:0] d);
      d[1] = d[1] & speedRangeSelect[ch];
      exp[ch] = d;
      host.put(1'b1, ch, d);
      @(posedge mclk);
   endtask
   task automatic settle(input string name);
      host.put(1'b0, 2'h0, 8'h00);
      speedRangeSelect <= 4'($random(seed)) | {exp[3][1], exp[2][1], exp[1][1], exp[0][1]};
      repeat (3) @(posedge mclk);
      #1 checkAll(name);
      @(posedge mclk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      #1 checkAll("reset");
      @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int k = 0; k < 6; k++) begin
         for (int c = 0; c < 4; c++) wr(2'(c), corner[(k + c) % 6]);
         settle("corner");
      end
      repeat (6) begin
         repeat (10) wr(2'($random(seed)), 8'($random(seed)));
         settle("random");
      end
      for (int c = 0; c < 4; c++) wr(2'(c), 8'hc1);
      settle("enables");
      #1 rst_n <= 1'b0;
      #1 chk({dut.primaryOutputEnable, dut.secondaryOutputEnable}, 8'h00);
      foreach (exp[i]) exp[i] = 8'h35;
      @(posedge mclk);
      rst_n <= 1'b1;
      host.put(1'b1, 2'h1, 8'hc2);
      @(posedge mclk);
      settle("refused");
      results;
   end
   initial begin
      #100000;
      num_errors++;
      results;
   end
endmodule
